//--- hw/leb_defs.svh
`ifndef LEB_DEFS_SVH
`define LEB_DEFS_SVH

// Register indices as printed (word indices); byte address is 4x
`define LEB_IDX_CTRL        16'h0c7a
`define LEB_IDX_DELAY       16'h0c7c
`define LEB_IDX_AUX         16'h0c7e
`define LEB_IDX_STATUS      16'h0c80

// Control register field positions
`define LEB_BIT_HI_RISE     15
`define LEB_BIT_HI_FALL     14
`define LEB_BIT_LO_RISE     13
`define LEB_BIT_LO_FALL     12
`define LEB_BIT_FLT_EN      11
`define LEB_BIT_CL_EN       10
`define LEB_BIT_AUX_HI      5
`define LEB_BIT_AUX_LO      4
`define LEB_BIT_HO_HI       3
`define LEB_BIT_HO_LO       2
`define LEB_BIT_LO_HI       1
`define LEB_BIT_LO_LO       0

// Writable masks and reset values
`define LEB_CTRL_MASK       16'hfc3f
`define LEB_DELAY_MASK      16'h0fff
`define LEB_AUX_SEL_LSB     8
`define LEB_AUX_MASK        16'h0f00
`define LEB_CTRL_RST        16'h0000
`define LEB_DELAY_RST       16'h0000
`define LEB_AUX_RST         16'h0000

`endif

//--- hw/leb_pkg.sv
package leb_pkg;

    // Fault and current-limit pair carried together
    typedef struct packed {
        logic fault;
        logic curlim;
    } leb_prot_t;

    // PWM output pair
    typedef struct packed {
        logic hi;
        logic lo;
    } leb_pwm_t;

endpackage : leb_pkg

//--- hw/leb_blank.sv
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`include "leb_defs.svh"

// Function
// R01 - Four enables pick which output edges restart blanking; others ignored
// R02 - Two enables decide whether edge blanking masks fault and current-limit
// R03 - Enables mask both inputs while high-side output is high or low
// R04 - Same level masking choice exists for the low-side output
// R05 - Enables mask both inputs while selected auxiliary signal is high/low
// R06 - Auxiliary source select is four bits in the auxiliary control register
// R07 - Control register at own address, resets to zero, unused bits read zero
// R08 - Enabled edge loads delay counter; masks hold until expiry, edges restart
module leb_blank
    import leb_pkg::*;
#(
    parameter int DLY_W = 12,
    parameter int NAUX  = 16
)(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [15:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire leb_pwm_t          pwm_out,
    input  wire logic [NAUX-1:0]   aux_blank_src,
    input  wire leb_prot_t         prot_in,
    output leb_prot_t              prot_out,
    output logic                   blanking
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [15:0]      ctrl_ff;
    logic [15:0]      dly_ff;
    logic [15:0]      aux_ff;
    logic [31:0]      prdata_ff;
    logic             err_ff;

    // Printed offsets are word indices, so each is scaled by 4 to a byte address
    wire logic        hit_ctrl  = paddr == 16'(`LEB_IDX_CTRL * 4);
    wire logic        hit_dly   = paddr == 16'(`LEB_IDX_DELAY * 4);
    wire logic        hit_aux   = paddr == 16'(`LEB_IDX_AUX * 4);
    wire logic        hit_stat  = paddr == 16'(`LEB_IDX_STATUS * 4);
    wire logic        hit_any   = hit_ctrl | hit_dly | hit_aux | hit_stat;
    wire logic        setup     = psel & ~penable;
    wire logic        wr_go     = psel & penable & pwrite & hit_any;
    wire logic [15:0] wdat      = pwdata[15:0];
    logic [15:0]      cnt_ff;
    logic [1:0]       pwm_d_ff;

    // Status word exposes the running counter and blanking state
    wire logic [31:0] rd_mux =
        hit_ctrl ? {16'h0000, ctrl_ff} :
        hit_dly  ? {16'h0000, dly_ff}  :
        hit_aux  ? {16'h0000, aux_ff}  :
        hit_stat ? {15'h0000, blanking, cnt_ff} : 32'h0000_0000;

    // Zero-wait slave: read data captured in setup, so access ends at once
    assign pready  = 1'b1;
    assign prdata  = prdata_ff;
    assign pslverr = err_ff & psel & penable;

    // Unused control bits are not stored and so read zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff <= `LEB_CTRL_RST; // R07
            dly_ff  <= `LEB_DELAY_RST;
            aux_ff  <= `LEB_AUX_RST;
        end else if (wr_go) begin
            if (hit_ctrl) ctrl_ff <= wdat & `LEB_CTRL_MASK; // R07
            if (hit_dly)  dly_ff  <= wdat & `LEB_DELAY_MASK;
            if (hit_aux)  aux_ff  <= wdat & `LEB_AUX_MASK; // R06
        end
    end

    // Read data and error flag latched during setup
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_ff <= 32'h0000_0000;
            err_ff    <= 1'b0;
        end else if (setup) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            err_ff    <= ~hit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detection and counter

    // PWM outputs come from same-clock generator logic, no synchroniser
    wire logic [1:0]  pwm_now  = {pwm_out.hi, pwm_out.lo};
    wire logic        hi_rise  = pwm_now[1] & ~pwm_d_ff[1];
    wire logic        hi_fall  = ~pwm_now[1] & pwm_d_ff[1];
    wire logic        lo_rise  = pwm_now[0] & ~pwm_d_ff[0];
    wire logic        lo_fall  = ~pwm_now[0] & pwm_d_ff[0];
    wire logic        trig     =
        (hi_rise & ctrl_ff[`LEB_BIT_HI_RISE]) |
        (hi_fall & ctrl_ff[`LEB_BIT_HI_FALL]) |
        (lo_rise & ctrl_ff[`LEB_BIT_LO_RISE]) |
        (lo_fall & ctrl_ff[`LEB_BIT_LO_FALL]); // R01
    wire logic [15:0] nxt_cnt  =
        trig ? dly_ff : ((cnt_ff != 16'h0000) ? cnt_ff - 16'h0001
                                              : 16'h0000); // R08

    // Each enabled edge reloads, so back-to-back edges extend the window
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwm_d_ff <= 2'h0;
            cnt_ff   <= 16'h0000;
        end else begin
            pwm_d_ff <= pwm_now;
            cnt_ff   <= nxt_cnt; // R08
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Masking

    wire logic [3:0]  aux_sel  = aux_ff[`LEB_AUX_SEL_LSB +: 4]; // R06
    wire logic        aux_lvl  = (32'(aux_sel) < NAUX) ?
                                 aux_blank_src[aux_sel] : 1'b0; // R05
    // Edge window active whenever the counter is not yet zero
    wire logic        edge_win = cnt_ff != 16'h0000; // R08
    wire logic        state_bl =
        (aux_lvl     & ctrl_ff[`LEB_BIT_AUX_HI]) |
        (~aux_lvl    & ctrl_ff[`LEB_BIT_AUX_LO]) | // R05
        (pwm_now[1]  & ctrl_ff[`LEB_BIT_HO_HI])  |
        (~pwm_now[1] & ctrl_ff[`LEB_BIT_HO_LO])  | // R03
        (pwm_now[0]  & ctrl_ff[`LEB_BIT_LO_HI])  |
        (~pwm_now[0] & ctrl_ff[`LEB_BIT_LO_LO]);   // R04
    wire logic        mask_flt = (edge_win & ctrl_ff[`LEB_BIT_FLT_EN])
                                 | state_bl; // R02
    wire logic        mask_cl  = (edge_win & ctrl_ff[`LEB_BIT_CL_EN])
                                 | state_bl; // R02

    wire logic        nxt_blank = edge_win | state_bl;

    ////////////////////////////////////////////////////////////////////////
    // Protection path

    leb_prot_t        prot_s1_ff;
    leb_prot_t        prot_s2_ff;
    leb_prot_t        prot_out_ff;
    logic             blank_ff;

    // Masks apply to the synchronised level; only the second stage is read
    wire leb_prot_t   nxt_prot_out = {prot_s2_ff.fault & ~mask_flt,
                                      prot_s2_ff.curlim & ~mask_cl};

    // Comparators sit outside this clock domain, so two stages first;
    // the price is two cycles of extra delay on a genuine fault
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prot_s1_ff <= 2'h0;
            prot_s2_ff <= 2'h0;
        end else begin
            prot_s1_ff <= prot_in;
            prot_s2_ff <= prot_s1_ff;
        end
    end

    // Registered outputs keep decode glitches off the shutdown logic
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prot_out_ff <= 2'h0;
            blank_ff    <= 1'b0;
        end else begin
            prot_out_ff <= nxt_prot_out; // R02
            blank_ff    <= nxt_blank; // R08
        end
    end

    assign prot_out = prot_out_ff;
    assign blanking = blank_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Outputs are registered, so each mask shows one cycle after its cause
    AST_EDGE_IGNORED: assert property (@(posedge clk) // R01
        disable iff (sys_rst)
        (hi_rise & ~ctrl_ff[`LEB_BIT_HI_RISE] & ~lo_rise & ~lo_fall
         & cnt_ff == 16'h0000) |=> cnt_ff == 16'h0000)
        else $error("disabled edge started blanking");
    AST_FLT_PASS: assert property (@(posedge clk) // R02
        disable iff (sys_rst)
        (~ctrl_ff[`LEB_BIT_FLT_EN] & ~state_bl)
        |=> prot_out.fault == $past(prot_s2_ff.fault))
        else $error("fault masked while edge mask disabled");
    AST_CL_MASK: assert property (@(posedge clk) // R02
        disable iff (sys_rst)
        (ctrl_ff[`LEB_BIT_CL_EN] & edge_win) |=> !prot_out.curlim)
        else $error("current limit passed during edge window");
    AST_HI_STATE: assert property (@(posedge clk) // R03
        disable iff (sys_rst)
        (ctrl_ff[`LEB_BIT_HO_HI] & pwm_out.hi)
        |=> !prot_out.fault && !prot_out.curlim)
        else $error("high-side high did not mask");
    AST_LO_STATE: assert property (@(posedge clk) // R04
        disable iff (sys_rst)
        (ctrl_ff[`LEB_BIT_LO_LO] & !pwm_out.lo)
        |=> !prot_out.fault && !prot_out.curlim)
        else $error("low-side low did not mask");
    AST_AUX_STATE: assert property (@(posedge clk) // R05
        disable iff (sys_rst)
        (ctrl_ff[`LEB_BIT_AUX_HI] & aux_lvl) |=> !prot_out.fault)
        else $error("aux high did not mask");
    AST_AUX_WRITE: assert property (@(posedge clk) // R06
        disable iff (sys_rst)
        (wr_go & hit_aux) |=> aux_ff[15:12] == 4'h0)
        else $error("aux reserved bits stored");
    AST_CTRL_ZERO: assert property (@(posedge clk) // R07
        disable iff (sys_rst)
        (ctrl_ff & ~`LEB_CTRL_MASK) == 16'h0000)
        else $error("unimplemented control bit set");
    AST_LOAD: assert property (@(posedge clk) // R08
        disable iff (sys_rst)
        trig |=> cnt_ff == $past(dly_ff))
        else $error("counter not loaded on edge");
    AST_COUNT: assert property (@(posedge clk) // R08
        disable iff (sys_rst)
        (!trig && cnt_ff != 16'h0000)
        |=> cnt_ff == $past(cnt_ff) - 16'h0001)
        else $error("counter did not decrement");
    // Delay never exceeds the counter range the channel was built for
    AST_DLY_RANGE: assert property (@(posedge clk) // R08
        disable iff (sys_rst)
        (dly_ff >> DLY_W) == 16'h0000)
        else $error("delay wider than counter range");
    AST_BLANK_OUT: assert property (@(posedge clk) // R08
        disable iff (sys_rst)
        edge_win |=> blanking)
        else $error("blanking flag low during edge window");

    CV_EDGE:  cover property (@(posedge clk) disable iff (sys_rst)
        trig ##1 edge_win ##[1:20] !edge_win);
    CV_RETRIG: cover property (@(posedge clk) disable iff (sys_rst)
        edge_win && trig);
    CV_STATE: cover property (@(posedge clk) disable iff (sys_rst)
        state_bl && prot_s2_ff.fault);
    CV_AUX:   cover property (@(posedge clk) disable iff (sys_rst)
        aux_lvl && ctrl_ff[`LEB_BIT_AUX_HI]);

endmodule : leb_blank

//--- tb/leb_far_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
// Far side: PWM output stage and protection comparators
module leb_far_model
    import leb_pkg::*;
(
    input  wire logic clk,
    output leb_pwm_t  pwm_out,
    output leb_prot_t prot_in
);
    // Idle low; a real stage only moves just after a rising edge
    initial begin
        pwm_out = '0;
        prot_in = '0;
    end
    task automatic drive(input leb_pwm_t p, input leb_prot_t f);
        @(posedge clk);
        pwm_out <= p;
        prot_in <= f;
    endtask : drive
endmodule : leb_far_model

//--- tb/tb.sv
`timescale 1ns/10ps
`include "leb_defs.svh"
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin \
    bad_count++; $display("wrong value %s exp %h got %h", nm, e, s); \
    end end
////////////////////////////////////////////////////////////////////////
module tb
    import leb_pkg::*;
;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, blanking, err;
    logic [15:0] aux_src = '0;
    leb_pwm_t    pwm;
    leb_prot_t   prot_in, prot_out;
    int          bad_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    localparam logic [15:0] A_CTRL = 16'(`LEB_IDX_CTRL * 4);
    localparam logic [15:0] A_DLY  = 16'(`LEB_IDX_DELAY * 4);
    localparam logic [15:0] A_AUX  = 16'(`LEB_IDX_AUX * 4);
    localparam int          D      = 5;
    always #2 clk = ~clk;
    leb_blank dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pwm_out(pwm),
        .aux_blank_src(aux_src), .prot_in, .prot_out, .blanking);
    leb_far_model far (.clk(clk), .pwm_out(pwm), .prot_in(prot_in));
    ////////////////////////////////////////////////////////////////////
    // One APB transfer; never assumes the wait, the timeout ends a hang
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Control reset value, read-only gaps, select field, unmapped access
    task automatic t_regs();
        apb(1'b0, A_CTRL, '0);
        `CHK("ctrl reset", 32'h0, rd)
        apb(1'b1, A_CTRL, 32'hffff_ffff);
        apb(1'b0, A_CTRL, '0);
        `CHK("ctrl rw", 32'h0000_fc3f, rd)
        apb(1'b1, A_AUX, 32'hffff_ffff);
        apb(1'b0, A_AUX, '0);
        `CHK("aux sel", 32'h0000_0f00, rd)
        apb(1'b0, 16'h0004, '0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped ready", 1'b1, pready)
    endtask : t_regs
    // Each trigger edge alone; the same edge of the other output before it must be ignored
    task automatic t_edges();
        leb_pwm_t  st [4] = '{2'b01, 2'b10, 2'b10, 2'b01};
        leb_pwm_t  tr [4] = '{2'b11, 2'b00, 2'b11, 2'b00};
        leb_prot_t m;
        // Raise both comparator inputs early so the synchroniser settles
        far.drive(2'b00, 2'b11);
        apb(1'b1, A_DLY, D);
        for (int i = 0; i < 4; i++) begin
            m = (i % 2) ? 2'b10 : 2'b01;
            apb(1'b1, A_CTRL,
                32'(16'h8000 >> i) | (i % 2 ? 32'h400 : 32'h800));
            far.drive(st[i], 2'b11);
            // One edge loads the counter, one more for the output register
            repeat (2) @(posedge clk);
            #1 `CHK("ignored edge", 2'b11, prot_out)
            far.drive(tr[i], 2'b11);
            repeat (2) @(posedge clk);
            #1 `CHK("window start", m, prot_out)
            `CHK("window flag", 1'b1, blanking)
            repeat (D - 1) @(posedge clk);
            #1 `CHK("window end", m, prot_out)
            @(posedge clk);
            #1 `CHK("window over", 2'b11, prot_out)
        end
    endtask : t_edges
    // A second enabled edge inside the window restarts the full delay
    task automatic t_retrig();
        apb(1'b1, A_CTRL, 32'h0000_c800);
        far.drive(2'b10, 2'b11);
        far.drive(2'b00, 2'b11);
        repeat (D + 1) @(posedge clk);
        #1 `CHK("retrig held", 2'b01, prot_out)
        `CHK("retrig flag", 1'b1, blanking)
        @(posedge clk);
        #1 `CHK("retrig over", 2'b11, prot_out)
    endtask : t_retrig
    // Level masks; unselected signals sit at the opposite level
    task automatic t_state();
        logic v;
        logic u;
        int   s;
        apb(1'b1, A_DLY, '0);
        apb(1'b1, A_AUX, 32'h0300);
        for (int b = 0; b < 6; b++) begin
            apb(1'b1, A_CTRL, 32'(1) << b);
            s = b / 2;
            for (int k = 0; k < 2; k++) begin
                v = k[0];
                u = ~v;
                far.drive({s == 1 ? v : u, s == 0 ? v : u}, 2'b11);
                aux_src <= (s == 2 ? v : u) ? 16'h0008 : 16'hfff7;
                @(posedge clk);
                #1 `CHK("lvl mask", v == b[0] ? 2'b00 : 2'b11, prot_out)
                `CHK("state flag", v == b[0], blanking)
                `CHK("aux mask", v == b[0], ~prot_out.fault)
            end
        end
    endtask : t_state
    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    // Main sequence; the run needs well under 1000 cycles
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_edges();
        t_retrig();
        t_state();
        report_and_stop();
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
endmodule : tb
